/* File: hw/dacc_regs.svh */
`ifndef DACC_REGS_SVH
`define DACC_REGS_SVH
// Register addresses (byte-wide register space of the control port)
`define DACC_ADDR_SOUND 8'h10
`define DACC_ADDR_VOLUME 8'h11
`define DACC_ADDR_MUX 8'h40
`define DACC_ADDR_RESTORE 8'h7f
`define DACC_ADDR_INTERP 8'h18
`define DACC_ADDR_INPUT 8'h38
`define DACC_ADDR_IRQ_STAT 8'h50
`define DACC_ADDR_IRQ_MASK 8'h51
// Field positions
`define DACC_SOUND_MUTE 0
`define DACC_SOUND_DE_LO 1
`define DACC_SOUND_DE_HI 2
`define DACC_MUX_PLLRST 0
`define DACC_MUX_LLMUTE 1
`define DACC_VOL_HI 5
`define DACC_VOL_LO 0
`define DACC_INTERP_MUTE 0
`define DACC_IN_ACC_LO 0
`define DACC_IN_ACC_HI 1
`define DACC_IN_PRE 3
`define DACC_IN_NONPCM 5
`define DACC_IN_ASF_LO 6
`define DACC_IN_ASF_HI 7
`define DACC_IN_SPDLOCK 8
`define DACC_IN_PLLLOCK 10
// Reset values
`define DACC_RST_DEEMPH 2'h0
`define DACC_RST_MUTE 1'h1
`define DACC_RST_VOLUME 6'h00
`define DACC_RST_LLMUTE 1'h1
`define DACC_RST_PLLRST 1'h0
`define DACC_RDATA_IDLE 16'h0000
// Volume codes
`define DACC_VOL_ZERO_MAX 6'h01
`define DACC_VOL_LAST 6'h3d
`define DACC_VOL_SILENT 6'h3f
`define DACC_ATTEN_SILENT 7'h7f
`define DACC_ATTEN_ZERO 7'h00
`define DACC_ATTEN_STEP 7'h01
// Interrupt event bits
`define DACC_EV_PLL_LOSS 0
`define DACC_EV_SPD_LOSS 1
`define DACC_EV_RATE 2
`define DACC_EV_NONPCM 3
`define DACC_EV_NUM 4
`endif

/* File: hw/dacc_pkg.sv */
package dacc_pkg;
	typedef enum logic [1:0] {
		DACC_DE_OFF,
		DACC_DE_32K,
		DACC_DE_44K1,
		DACC_DE_48K
	} dacc_deemph_t;
	typedef enum logic [1:0] {
		DACC_FS_44K1,
		DACC_FS_UNDEF,
		DACC_FS_48K,
		DACC_FS_32K
	} dacc_rate_t;
	typedef enum logic [1:0] {
		DACC_ACC_LEVEL2,
		DACC_ACC_LEVEL1,
		DACC_ACC_LEVEL3,
		DACC_ACC_UNDEF
	} dacc_accuracy_t;
endpackage

/* File: hw/dacc_status_if.sv */
`timescale 1ns/10ps
// Synchronised decoder status passed from the input stage to the register bank
interface dacc_status_if;
	logic pll_lock;
	logic iec_input_lock_flag;
	logic non_pcm;
	logic pre_emph;
	logic [1:0] rate;
	logic [1:0] accuracy;
	modport src (output pll_lock, iec_input_lock_flag, non_pcm, pre_emph, rate, accuracy);
	modport dst (input pll_lock, iec_input_lock_flag, non_pcm, pre_emph, rate, accuracy);
endinterface

/* File: hw/dacc_sync.sv */
`timescale 1ns/10ps
// Three-stage synchroniser for decoder status; a change is taken once stages two and three agree
module dacc_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic pll_lock_in,
	input wire logic dec_lock_in,
	input wire logic non_pcm_in,
	input wire logic pre_emph_in,
	input wire logic [1:0] rate_in,
	input wire logic [1:0] accuracy_in,
	dacc_status_if.src st
);
	localparam int W = 8;
	logic [W-1:0] raw;
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] held;

	assign raw = {accuracy_in, rate_in, pre_emph_in, non_pcm_in, dec_lock_in, pll_lock_in};

	// Three flops per bit; the first stage feeds only the second
	always_ff @(posedge clk) begin
		if (rst) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= raw;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accept a new value per bit only when the last two stages agree
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clk) begin
				if (rst) begin
					held[i] <= 1'b0;
				end else if (s2[i] == s3[i]) begin
					held[i] <= s3[i];
				end
			end
		end
	endgenerate

	assign st.pll_lock = held[0];
	// Input lock counts only with PCM data present
	assign st.iec_input_lock_flag = held[1] & ~held[2];
	assign st.non_pcm = held[2];
	assign st.pre_emph = held[3];
	assign st.rate = held[5:4];
	assign st.accuracy = held[7:6];
endmodule

/* File: hw/dacc_ctrl.sv */
`timescale 1ns/10ps
`include "dacc_regs.svh"
module dacc_ctrl
	import dacc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [15:0] rdata,
	input wire logic pll_lock_in,
	input wire logic dec_lock_in,
	input wire logic non_pcm_in,
	input wire logic pre_emph_in,
	input wire logic [1:0] rate_in,
	input wire logic [1:0] accuracy_in,
	output logic [1:0] deemph_select,
	output logic deemph_enable,
	output logic [6:0] atten_db,
	output logic soft_mute,
	output logic hard_mute,
	output logic pll_reset,
	output logic irq
);
	dacc_status_if st ();

	logic [1:0] deemph_sel_reg;
	logic soft_mute_enable;
	logic [5:0] volume_code;
	logic lock_loss_mute_enable;
	logic pll_reset_req;
	logic [`DACC_EV_NUM-1:0] irq_stat;
	logic [`DACC_EV_NUM-1:0] irq_mask;
	logic [`DACC_EV_NUM-1:0] events;
	logic prev_pll_lock;
	logic prev_iec_input_lock_flag;
	logic prev_non_pcm;
	logic [1:0] prev_rate;
	logic mute_status_flag;
	logic [6:0] next_atten;
	logic next_hard_mute;
	logic [15:0] next_rdata;
	logic restore;
	logic wr_sound;
	logic wr_volume;
	logic wr_mux;
	logic wr_stat;
	logic wr_mask;
	logic [15:0] input_word;

	dacc_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pll_lock_in(pll_lock_in),
		.dec_lock_in(dec_lock_in),
		.non_pcm_in(non_pcm_in),
		.pre_emph_in(pre_emph_in),
		.rate_in(rate_in),
		.accuracy_in(accuracy_in),
		.st(st)
	);

	// Address match used by every write decode
	function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_addr);
		hit = (a == ref_addr);
	endfunction

	// Codes past the last step are silent; 62 is undefined and muted on purpose
	function automatic logic vol_silent(input logic [5:0] code);
		vol_silent = (code > `DACC_VOL_LAST);
	endfunction

	// Write to the restore address; data is ignored
	assign restore = wr && hit(addr, `DACC_ADDR_RESTORE);

	// Write decode per register, shared by the storage processes below
	assign wr_sound = wr && hit(addr, `DACC_ADDR_SOUND);
	assign wr_volume = wr && hit(addr, `DACC_ADDR_VOLUME);
	assign wr_mux = wr && hit(addr, `DACC_ADDR_MUX);
	assign wr_stat = wr && hit(addr, `DACC_ADDR_IRQ_STAT);
	assign wr_mask = wr && hit(addr, `DACC_ADDR_IRQ_MASK);

	// De-emphasis selection; restore brings back the filter-off default
	always_ff @(posedge clk) begin
		if (rst || restore) begin
			deemph_sel_reg <= `DACC_RST_DEEMPH;
		end else if (wr_sound) begin
			deemph_sel_reg <= wdata[`DACC_SOUND_DE_HI:`DACC_SOUND_DE_LO];
		end
	end

	// Soft mute enable; set out of reset so nothing plays before the host sets up
	always_ff @(posedge clk) begin
		if (rst || restore) begin
			soft_mute_enable <= `DACC_RST_MUTE;
		end else if (wr_sound) begin
			soft_mute_enable <= wdata[`DACC_SOUND_MUTE];
		end
	end

	// Volume register
	always_ff @(posedge clk) begin
		if (rst || restore) begin
			volume_code <= `DACC_RST_VOLUME;
		end else if (wr_volume) begin
			volume_code <= wdata[`DACC_VOL_HI:`DACC_VOL_LO];
		end
	end

	// Lock-loss mute enable; reserved bits above are not stored, so a stray one is harmless
	always_ff @(posedge clk) begin
		if (rst || restore) begin
			lock_loss_mute_enable <= `DACC_RST_LLMUTE;
		end else if (wr_mux) begin
			lock_loss_mute_enable <= wdata[`DACC_MUX_LLMUTE];
		end
	end

	// PLL reset request; restore clears it, as it resets every setting except the interrupt mask
	always_ff @(posedge clk) begin
		if (rst || restore) begin
			pll_reset_req <= `DACC_RST_PLLRST;
		end else if (wr_mux) begin
			pll_reset_req <= wdata[`DACC_MUX_PLLRST];
		end
	end

	// Volume code to attenuation in dB; 127 stands for full silence
	always_comb begin
		if (volume_code <= `DACC_VOL_ZERO_MAX) begin
			next_atten = `DACC_ATTEN_ZERO;
		end else if (volume_code <= `DACC_VOL_LAST) begin
			next_atten = {1'b0, volume_code} - `DACC_ATTEN_STEP;
		end else if (volume_code == `DACC_VOL_SILENT) begin
			next_atten = `DACC_ATTEN_SILENT;
		end else begin
			// Code 62 is not defined; silence is the safe choice
			next_atten = `DACC_ATTEN_SILENT;
		end
	end

	// Lock loss mutes only while the enable is set
	assign next_hard_mute = lock_loss_mute_enable && !st.pll_lock;

	// De-emphasis code to the filter, registered like every output
	always_ff @(posedge clk) begin
		if (rst) begin
			deemph_select <= `DACC_RST_DEEMPH;
		end else begin
			deemph_select <= deemph_sel_reg;
		end
	end

	// Filter enable; code 00 means no de-emphasis at all
	always_ff @(posedge clk) begin
		if (rst) begin
			deemph_enable <= 1'b0;
		end else begin
			deemph_enable <= (deemph_sel_reg != DACC_DE_OFF);
		end
	end

	// Attenuation shared by both channels
	always_ff @(posedge clk) begin
		if (rst) begin
			atten_db <= `DACC_ATTEN_ZERO;
		end else begin
			atten_db <= next_atten;
		end
	end

	// Soft mute to the interpolator
	always_ff @(posedge clk) begin
		if (rst) begin
			soft_mute <= `DACC_RST_MUTE;
		end else begin
			soft_mute <= soft_mute_enable;
		end
	end

	// Hard mute; one flop after the synchroniser, so it trails lock loss by a cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			hard_mute <= 1'b0;
		end else begin
			hard_mute <= next_hard_mute;
		end
	end

	// PLL reset to the clock regenerator
	always_ff @(posedge clk) begin
		if (rst) begin
			pll_reset <= `DACC_RST_PLLRST;
		end else begin
			pll_reset <= pll_reset_req;
		end
	end

	// Interpolator is muting on soft mute, hard mute or silent volume
	always_ff @(posedge clk) begin
		if (rst) begin
			mute_status_flag <= `DACC_RST_MUTE;
		end else begin
			mute_status_flag <= soft_mute_enable || next_hard_mute
				|| vol_silent(volume_code);
		end
	end

	// Previous lock levels for the loss events
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_pll_lock <= 1'b0;
			prev_iec_input_lock_flag <= 1'b0;
		end else begin
			prev_pll_lock <= st.pll_lock;
			prev_iec_input_lock_flag <= st.iec_input_lock_flag;
		end
	end

	// Previous stream content; reset matches the synchroniser, so no false event follows
	always_ff @(posedge clk) begin
		if (rst) begin
			prev_non_pcm <= 1'b0;
			prev_rate <= 2'h0;
		end else begin
			prev_non_pcm <= st.non_pcm;
			prev_rate <= st.rate;
		end
	end

	// One-cycle event pulses from the synchronised status
	always_comb begin
		events = '0;
		events[`DACC_EV_PLL_LOSS] = prev_pll_lock && !st.pll_lock;
		events[`DACC_EV_SPD_LOSS] = prev_iec_input_lock_flag && !st.iec_input_lock_flag;
		events[`DACC_EV_RATE] = (prev_rate != st.rate);
		events[`DACC_EV_NONPCM] = !prev_non_pcm && st.non_pcm;
	end

	// Sticky status per event, write one to clear; a new event wins over the clear
	genvar e;
	generate
		for (e = 0; e < `DACC_EV_NUM; e++) begin : g_stat
			always_ff @(posedge clk) begin
				if (rst) begin
					irq_stat[e] <= 1'b0;
				end else if (events[e]) begin
					irq_stat[e] <= 1'b1;
				end else if (wr_stat && wdata[e]) begin
					irq_stat[e] <= 1'b0;
				end
			end
		end
	endgenerate

	// Mask is not touched by restore: it is not a sound setting
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask <= '0;
		end else if (wr_mask) begin
			irq_mask <= wdata[`DACC_EV_NUM-1:0];
		end
	end

	// Level interrupt; stays high until software clears or masks the cause
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat & irq_mask);
		end
	end

	// Live decoder status word; nothing is latched, so a read shows the present state
	always_comb begin
		input_word = `DACC_RDATA_IDLE;
		input_word[`DACC_IN_PLLLOCK] = st.pll_lock;
		input_word[`DACC_IN_SPDLOCK] = st.iec_input_lock_flag;
		input_word[`DACC_IN_ASF_HI:`DACC_IN_ASF_LO] = st.rate;
		input_word[`DACC_IN_NONPCM] = st.non_pcm;
		input_word[`DACC_IN_PRE] = st.pre_emph;
		input_word[`DACC_IN_ACC_HI:`DACC_IN_ACC_LO] = st.accuracy;
	end

	// Read mux; status fields are sampled at the read itself
	always_comb begin
		next_rdata = `DACC_RDATA_IDLE;
		case (addr)
			`DACC_ADDR_SOUND: begin
				next_rdata[`DACC_SOUND_DE_HI:`DACC_SOUND_DE_LO] = deemph_sel_reg;
				next_rdata[`DACC_SOUND_MUTE] = soft_mute_enable;
			end
			`DACC_ADDR_VOLUME: begin
				next_rdata[`DACC_VOL_HI:`DACC_VOL_LO] = volume_code;
			end
			`DACC_ADDR_MUX: begin
				next_rdata[`DACC_MUX_LLMUTE] = lock_loss_mute_enable;
				next_rdata[`DACC_MUX_PLLRST] = pll_reset_req;
			end
			`DACC_ADDR_INTERP: begin
				next_rdata[`DACC_INTERP_MUTE] = mute_status_flag;
			end
			`DACC_ADDR_INPUT: begin
				next_rdata = input_word;
			end
			`DACC_ADDR_IRQ_STAT: begin
				next_rdata[`DACC_EV_NUM-1:0] = irq_stat;
			end
			`DACC_ADDR_IRQ_MASK: begin
				next_rdata[`DACC_EV_NUM-1:0] = irq_mask;
			end
			default: begin
				next_rdata = `DACC_RDATA_IDLE;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdata <= `DACC_RDATA_IDLE;
		end else if (rd) begin
			rdata <= next_rdata;
		end else begin
			rdata <= `DACC_RDATA_IDLE;
		end
	end
endmodule

/* File: testbench/dacc_ctrl_asserts.sv */
`timescale 1ns/10ps
// Sees only the top ports; writes land one edge after the strobe, outputs one later
module dacc_ctrl_asserts (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [15:0] rdata,
	input wire logic pll_lock_in,
	input wire logic dec_lock_in,
	input wire logic non_pcm_in,
	input wire logic pre_emph_in,
	input wire logic [1:0] rate_in,
	input wire logic [1:0] accuracy_in,
	input wire logic [1:0] deemph_select,
	input wire logic deemph_enable,
	input wire logic [6:0] atten_db,
	input wire logic soft_mute,
	input wire logic hard_mute,
	input wire logic pll_reset,
	input wire logic irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	deemph_en_a: assert property (deemph_enable == (deemph_select != 2'h0))
		else $error("de-emphasis enable wrong");
	mute_wr_a: assert property (wr && addr == 8'h10 |-> ##2
		soft_mute == $past(wdata[0], 2) && deemph_select == $past(wdata[2:1], 2))
		else $error("sound write not applied");
	vol_zero_a: assert property (wr && addr == 8'h11 && wdata[5:0] < 6'h02 |-> ##2
		atten_db == 7'h00) else $error("low volume code not at full level");
	vol_range_a: assert property (atten_db <= 7'h3c || atten_db == 7'h7f)
		else $error("attenuation out of range");
	vol_map_a: assert property (wr && addr == 8'h11 && wdata[5:0] > 6'h01 &&
		wdata[5:0] < 6'h3e |-> ##2 atten_db == {1'b0, $past(wdata[5:0], 2)} - 7'h01)
		else $error("volume step wrong");
	vol_silent_a: assert property (wr && addr == 8'h11 && wdata[5:0] == 6'h3f
		|-> ##2 atten_db == 7'h7f) else $error("silence code wrong");
	lock_mute_a: assert property (pll_lock_in [*8] |-> !hard_mute)
		else $error("hard mute while locked");
	pll_wr_a: assert property (wr && addr == 8'h40 |-> ##2 pll_reset == $past(wdata[0], 2))
		else $error("pll reset not applied");
	restore_a: assert property (wr && addr == 8'h7f |-> ##2 soft_mute && !pll_reset &&
		atten_db == 7'h00 && deemph_select == 2'h0) else $error("restore incomplete");
	rdata_idle_a: assert property (!$past(rd) |-> rdata == 16'h0000)
		else $error("read data outside its cycle");
endmodule
bind dacc_ctrl dacc_ctrl_asserts u_chk (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata(rdata), .pll_lock_in(pll_lock_in), .dec_lock_in(dec_lock_in),
	.non_pcm_in(non_pcm_in), .pre_emph_in(pre_emph_in), .rate_in(rate_in),
	.accuracy_in(accuracy_in), .deemph_select(deemph_select), .deemph_enable(deemph_enable),
	.atten_db(atten_db), .soft_mute(soft_mute), .hard_mute(hard_mute),
	.pll_reset(pll_reset), .irq(irq));

/* File: testbench/dacc_dec_model.sv */
`timescale 1ns/10ps
// Stream decoder model; levels move only just after a clock edge
module dacc_dec_model (
	input wire logic clk,
	output logic pll_lock,
	output logic dec_lock,
	output logic non_pcm,
	output logic pre_emph,
	output logic [1:0] rate,
	output logic [1:0] accuracy
);
	initial {pll_lock, dec_lock, non_pcm, pre_emph, rate, accuracy} = 8'hc0;
	// Order: clock lock, decoder lock, non-PCM, pre-emphasis, rate, accuracy
	task automatic set(input logic [7:0] v);
		@(posedge clk);
		{pll_lock, dec_lock, non_pcm, pre_emph, rate, accuracy} <= v;
	endtask
endmodule

/* File: testbench/dacc_ctrl_tb_top.sv */
`timescale 1ns/10ps
module dacc_ctrl_tb_top;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rd_d = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] v;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic [15:0] exp_q[$];
	logic [1:0] deemph_select, rate, accuracy;
	logic [6:0] atten_db;
	logic [5:0] c;
	logic [5:0] vt[6] = '{6'h00, 6'h01, 6'h02, 6'h3c, 6'h3d, 6'h3f};
	logic deemph_enable, soft_mute, hard_mute, pll_reset, irq;
	logic pll_lock, dec_lock, non_pcm, pre_emph;
	int err_count = 0;
	int total_checks = 0;
	int i;
	always #12.5 clk = ~clk;
	dacc_dec_model dec (.clk(clk), .pll_lock(pll_lock), .dec_lock(dec_lock),
		.non_pcm(non_pcm), .pre_emph(pre_emph), .rate(rate), .accuracy(accuracy));
	dacc_ctrl dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .pll_lock_in(pll_lock), .dec_lock_in(dec_lock),
		.non_pcm_in(non_pcm), .pre_emph_in(pre_emph), .rate_in(rate),
		.accuracy_in(accuracy), .deemph_select(deemph_select),
		.deemph_enable(deemph_enable), .atten_db(atten_db), .soft_mute(soft_mute),
		.hard_mute(hard_mute), .pll_reset(pll_reset), .irq(irq));
	task automatic check(input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Register read data against the queued note
	task automatic check_rd(input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR t=%0t read exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// The expectation is queued; the watcher below compares it
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	// Outputs follow a write by two edges; look between edges
	task automatic settle;
		repeat (2) @(negedge clk);
	endtask
	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// Read data stands only in the cycle after the strobe
	always @(posedge clk) rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d && exp_q.size() > 0)
			check_rd(exp_q.pop_front(), rdata);
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		finish_test;
	end
	initial begin
		v = 8'($urandom(66586));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd_reg(8'h10, 16'h0001);
		rd_reg(8'h11, 16'h0000);
		rd_reg(8'h40, 16'h0002);
		rd_reg(8'h22, 16'h0000);
		// Start-up string sets PLL reset, reserved bits kept low
		wr_reg(8'h40, 16'h0003);
		settle;
		check(16'h0001, {15'h0, pll_reset});
		wr_reg(8'h40, 16'h0002);
		$display("defaults and init done");
		for (i = 0; i < 8; i++) begin
			wr_reg(8'h10, 16'(i));
			settle;
			check({13'h0, i[2:1] != 2'h0, i[2:1]}, {13'h0, deemph_enable, deemph_select});
			check({15'h0, i[0]}, {15'h0, soft_mute});
			rd_reg(8'h10, 16'(i));
		end
		// Volume boundaries, then random codes from 0 to 61
		for (i = 0; i < 10; i++) begin
			c = (i < 6) ? vt[i] : 6'($urandom % 62);
			wr_reg(8'h11, {10'h0, c});
			settle;
			check({9'h0, c == 6'h3f ? 7'h7f : c < 6'h02 ? 7'h00 : 7'(c) - 7'h01},
				{9'h0, atten_db});
		end
		$display("control fields done");
		wr_reg(8'h10, 16'h0000);
		wr_reg(8'h11, 16'h0000);
		repeat (8) @(posedge clk);
		rd_reg(8'h18, 16'h0000);
		dec.set(8'h40);
		repeat (8) @(negedge clk);
		check(16'h0001, {15'h0, hard_mute});
		rd_reg(8'h18, 16'h0001);
		wr_reg(8'h40, 16'h0000);
		settle;
		check(16'h0000, {15'h0, hard_mute});
		rd_reg(8'h18, 16'h0000);
		$display("mute done");
		// Random stream states; wait out the synchroniser before reading
		for (i = 0; i < 12; i++) begin
			v = 8'($urandom);
			dec.set(v);
			repeat (6) @(posedge clk);
			rd_reg(8'h38, {5'h0, v[7], 1'b0, v[6] & ~v[5], v[3:2], v[5], 1'b0, v[4],
				1'b0, v[1:0]});
		end
		$display("status done");
		dec.set(8'hc0);
		repeat (8) @(posedge clk);
		wr_reg(8'h50, 16'h000f);
		wr_reg(8'h51, 16'h0001);
		dec.set(8'h40);
		repeat (8) @(negedge clk);
		check(16'h0001, {15'h0, irq});
		rd_reg(8'h50, 16'h0001);
		wr_reg(8'h51, 16'h0000);
		settle;
		check(16'h0000, {15'h0, irq});
		wr_reg(8'h51, 16'h0001);
		wr_reg(8'h50, 16'h0001);
		settle;
		check(16'h0000, {15'h0, irq});
		// Lock back, stream turns to other data at 48 kHz: three masked events at once
		dec.set(8'he8);
		repeat (8) @(negedge clk);
		check(16'h0000, {15'h0, irq});
		rd_reg(8'h50, 16'h000e);
		$display("interrupt done");
		wr_reg(8'h10, 16'h0006);
		wr_reg(8'h11, 16'h0020);
		wr_reg(8'h40, 16'h0001);
		wr_reg(8'h7f, 16'h0000);
		rd_reg(8'h10, 16'h0001);
		rd_reg(8'h11, 16'h0000);
		rd_reg(8'h40, 16'h0002);
		settle;
		check(16'h0000, {15'h0, pll_reset});
		$display("restore done");
		repeat (3) @(posedge clk);
		finish_test;
	end
endmodule
